// ### design/qbm_pkg.sv
// Purpose: Shared constants and carriers for the quadword bus master engine
// Assumes: One clock at 25 MHz
// Notes: Bus field encodings are plain defaults
package qbm_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int LATCH_HOLD_NS = 200;
  localparam int LATCH_HOLD_CYC = (LATCH_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_NS = 102400;
  localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CMD_MSB = 31;
  localparam int CMD_LSB = 28;
  localparam int ADDR_MSB = 27;
  localparam int CNT_MSB = 8;
  localparam int CNT_LSB = 1;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  // Tag codes
  localparam logic [2:0] TAG_READ_DATA = 3'h0;
  localparam logic [2:0] TAG_CMD_ADDR = 3'h3;
  localparam logic [2:0] TAG_WRITE_DATA = 3'h5;
  // Confirmation codes
  localparam logic [1:0] CNF_NONE = 2'h0;
  localparam logic [1:0] CNF_ACK = 2'h1;
  localparam logic [1:0] CNF_BUSY = 2'h2;
  localparam logic [1:0] CNF_ERR = 2'h3;
  // Commands with bit 0 high are reads
  localparam int CMD_READ_BIT = 28;
  // Avalon offsets
  localparam logic [3:0] OFS_CMD_ADDR = 4'h0;
  localparam logic [3:0] OFS_TX_FILE = 4'h4;
  localparam logic [3:0] OFS_BYTE_MASK = 4'h8;
  localparam logic [3:0] OFS_CONTROL = 4'hC;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0] tag;
    logic [4:0] id;
    logic [3:0] mask;
    logic valid;
  } qbm_busword_t;

  typedef struct packed {
    logic [31:0] data;
    logic [2:0] tag;
    logic [4:0] id;
    logic parityOk;
    logic valid;
  } qbm_rxword_t;
endpackage

// ### design/qbm_engine.sv
// Purpose: Quadword bus master engine: extended write and read transfers
// Assumes: Avalon-MM slave, bus inputs synchronous to clk
// Notes: Retries until ack, error or timeout
// Overview of operation
// - Command in top four bits, address below
// - Hold datapath word in latch 200 ns
// - Address bits 8:1 count after each transfer
// - Command load resets file pointer; writes advance
// - Byte mask strobe stores two four-bit masks
// - Unloaded mask defaults to all ones
// - Set A go raises go; busy too unless B is active
// - Win only if no higher request pending
// - Drive command/address, tag and priority ID
// - Write sends two longwords with own masks
// - No response or busy retries transfer
// - Retry beyond timeout sets timeout error
// - Error confirmation aborts and sets error
// - Timeout counter starts at command tag
// - Write ack clears go, raises done
// - Read ack sets expect longword flop
// - Accept data on ID, tag, parity match
// - First longword moves pointer, clears expect
// - Second longword clears go, raises done
// - Missing read data times out with error
// - Read pointer is busy B and select
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module qbm_engine #(
  parameter int TIMEOUT_CYCLES = qbm_pkg::TIMEOUT_CYC
) (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic [3:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon wait
  input wire logic [3:0] priority_level_code, // Jumpers
  input wire logic [15:0] arbIn, // Arbitration field in
  output logic [15:0] arbOut, // Our request line
  output qbm_pkg::qbm_busword_t busOut, // Transmitted word
  input wire logic [1:0] confirmation_in, // Confirmation
  input wire qbm_pkg::qbm_rxword_t busIn, // Received word
  output logic [31:0] rxWord0, // Receive file A word 1
  output logic [31:0] rxWord1, // Receive file A word 2
  output logic section_a_done, // A done pulse
  output logic section_b_done // B done pulse
);
  typedef enum {ST_IDLE, ST_ARB, ST_CA, ST_WD1, ST_WD2, ST_CNF, ST_RDWAIT} qbm_state_t;
  qbm_state_t state_ff;
  logic [31:0] latched_internal_bus_word_ff;
  logic [3:0] latchCnt_ff;
  logic [3:0] cmd_ff;
  logic [27:0] addr_ff;
  logic [7:0] addrCnt_ff;
  logic [1:0] file_write_pointer_ff;
  logic [31:0] txFile_ff [4];
  logic [7:0] byteMask_ff;
  logic maskLoaded_ff;
  logic goA_ff, goB_ff, activeB_ff;
  logic transmit_word_select_ff;
  logic [31:0] toCnt_ff;
  logic toRun_ff;
  logic cmd_addr_timeout_error_ff, cmd_addr_error_flag_ff, read_data_timeout_ff;
  logic expect_longword_flop_ff, expect_quadword_flop_ff;
  logic first_longword_received_ff;
  logic pendingLoad_ff;
  logic [1:0] pendingKind_ff;
  logic [31:0] nxt_readdata;
  logic section_a_busy, section_b_busy, goActive, confirm_timeout_expired;
  logic id_match, rxGood, receive_file_write_enable, isRead, higherPending;
  logic [1:0] txPtr;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  function automatic logic isHigher(input logic [15:0] req, input logic [3:0] lvl);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (req[i] && (i < int'(lvl))) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign section_a_busy = goA_ff && !activeB_ff;
  assign section_b_busy = activeB_ff;
  assign goActive = activeB_ff ? goB_ff : goA_ff;
  assign txPtr = {section_b_busy, transmit_word_select_ff};
  assign confirm_timeout_expired = toRun_ff && (toCnt_ff >= TIMEOUT_CYCLES - 1);
  assign id_match = busIn.id == {1'b0, priority_level_code};
  assign rxGood = busIn.valid && id_match && busIn.tag == qbm_pkg::TAG_READ_DATA
    && busIn.parityOk;
  assign receive_file_write_enable = expect_longword_flop_ff || expect_quadword_flop_ff;
  assign isRead = cmd_ff[qbm_pkg::CMD_READ_BIT - qbm_pkg::CMD_LSB];
  assign higherPending = isHigher(arbIn, priority_level_code);

  ////////////////////////////////////////////////////////////////////////
  // Avalon slave: writes wait while the latch holds the word
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest <= 1'b1;
      pendingLoad_ff <= 1'b0;
      pendingKind_ff <= 2'h0;
      latched_internal_bus_word_ff <= 32'h0;
      latchCnt_ff <= 4'h0;
    end else if (pendingLoad_ff) begin
      if (latchCnt_ff == 4'(qbm_pkg::LATCH_HOLD_CYC - 1)) begin
        pendingLoad_ff <= 1'b0;
        waitrequest <= 1'b0;
      end
      latchCnt_ff <= latchCnt_ff + 4'h1;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (write) begin
      latched_internal_bus_word_ff <= writedata;
      pendingLoad_ff <= 1'b1;
      pendingKind_ff <= address[3:2];
      latchCnt_ff <= 4'h0;
    end else if (read) begin
      waitrequest <= 1'b0;
    end
  end

  wire loadStrobe = pendingLoad_ff && latchCnt_ff == 4'(qbm_pkg::LATCH_HOLD_CYC - 1);
  wire load_cmd_addr_strobe = loadStrobe && pendingKind_ff == qbm_pkg::OFS_CMD_ADDR[3:2];
  wire load_transmit_file_strobe = loadStrobe && pendingKind_ff == qbm_pkg::OFS_TX_FILE[3:2];
  wire load_byte_mask_strobe = loadStrobe && pendingKind_ff == qbm_pkg::OFS_BYTE_MASK[3:2];
  wire controlStrobe = loadStrobe && pendingKind_ff == qbm_pkg::OFS_CONTROL[3:2];
  wire setAGo = controlStrobe && latched_internal_bus_word_ff[0];
  wire setBGo = controlStrobe && latched_internal_bus_word_ff[1];
  wire clrErr = controlStrobe && latched_internal_bus_word_ff[2];

  always_comb begin
    nxt_readdata = 32'h0;
    case (address[3:2])
      2'h0: nxt_readdata = {cmd_ff, addr_ff[27:9], addrCnt_ff, addr_ff[0]};
      2'h1: nxt_readdata = rxWord0;
      2'h2: nxt_readdata = {24'h0, byteMask_ff};
      default: nxt_readdata = {25'h0, read_data_timeout_ff, cmd_addr_error_flag_ff,
        cmd_addr_timeout_error_ff, section_b_busy, section_a_busy, goB_ff, goA_ff};
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (read && waitrequest && !pendingLoad_ff) begin
      readdata <= nxt_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command/address register and counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ff <= 4'h0;
      addr_ff <= 28'h0;
      addrCnt_ff <= 8'h0;
    end else if (load_cmd_addr_strobe) begin
      cmd_ff <= latched_internal_bus_word_ff[qbm_pkg::CMD_MSB:qbm_pkg::CMD_LSB];
      addr_ff <= latched_internal_bus_word_ff[qbm_pkg::ADDR_MSB:0];
      addrCnt_ff <= latched_internal_bus_word_ff[qbm_pkg::CNT_MSB:qbm_pkg::CNT_LSB];
    end else if (state_ff == ST_CNF && confirmation_in == qbm_pkg::CNF_ACK && !isRead) begin
      addrCnt_ff <= addrCnt_ff + 8'h1;
    end else if (state_ff == ST_RDWAIT && rxGood && expect_quadword_flop_ff
        && !expect_longword_flop_ff) begin
      addrCnt_ff <= addrCnt_ff + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit file and byte mask
  always_ff @(posedge clk) begin
    if (rst) begin
      file_write_pointer_ff <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        txFile_ff[i] <= 32'h0;
      end
    end else if (load_cmd_addr_strobe) begin
      file_write_pointer_ff <= 2'h0;
    end else if (load_transmit_file_strobe) begin
      txFile_ff[file_write_pointer_ff] <= latched_internal_bus_word_ff;
      file_write_pointer_ff <= file_write_pointer_ff + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      byteMask_ff <= qbm_pkg::MASK_RESET;
      maskLoaded_ff <= 1'b0;
    end else if (load_byte_mask_strobe) begin
      byteMask_ff <= latched_internal_bus_word_ff[7:0];
      maskLoaded_ff <= 1'b1;
    end else if (state_ff == ST_CNF && confirmation_in == qbm_pkg::CNF_ACK) begin
      byteMask_ff <= qbm_pkg::MASK_RESET;
      maskLoaded_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Go and busy flops per section
  wire finishOk = (state_ff == ST_CNF && confirmation_in == qbm_pkg::CNF_ACK && !isRead)
    || (state_ff == ST_RDWAIT && rxGood && expect_quadword_flop_ff && !expect_longword_flop_ff);
  wire abort = (state_ff == ST_CNF && (confirmation_in == qbm_pkg::CNF_ERR
    || confirm_timeout_expired)) || (state_ff == ST_RDWAIT && confirm_timeout_expired);
  wire goClear = finishOk || abort;

  always_ff @(posedge clk) begin
    if (rst) begin
      goA_ff <= 1'b0;
      goB_ff <= 1'b0;
      activeB_ff <= 1'b0;
      section_a_done <= 1'b0;
      section_b_done <= 1'b0;
    end else begin
      section_a_done <= goClear && !activeB_ff;
      section_b_done <= goClear && activeB_ff;
      if (goClear && !activeB_ff) begin
        goA_ff <= 1'b0;
        activeB_ff <= goB_ff || setBGo;
      end else if (setAGo) begin
        goA_ff <= 1'b1;
      end
      if (goClear && activeB_ff) begin
        goB_ff <= 1'b0;
        activeB_ff <= 1'b0;
      end else if (setBGo) begin
        goB_ff <= 1'b1;
        if (!goA_ff && !setAGo) begin
          activeB_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      transmit_word_select_ff <= 1'b0;
      arbOut <= 16'h0;
      busOut <= '0;
    end else begin
      busOut <= '0;
      arbOut <= 16'h0;
      case (state_ff)
        ST_IDLE: begin
          transmit_word_select_ff <= 1'b0;
          if (goActive) begin
            state_ff <= ST_ARB;
          end
        end
        ST_ARB: begin
          arbOut <= 16'(1) << priority_level_code;
          if (!higherPending) begin
            state_ff <= ST_CA;
          end
        end
        ST_CA: begin
          busOut.data <= {cmd_ff, addr_ff[27:9], addrCnt_ff, addr_ff[0]};
          busOut.tag <= qbm_pkg::TAG_CMD_ADDR;
          busOut.id <= {1'b0, priority_level_code};
          busOut.mask <= 4'hF;
          busOut.valid <= 1'b1;
          state_ff <= isRead ? ST_CNF : ST_WD1;
        end
        ST_WD1: begin
          busOut.data <= txFile_ff[txPtr];
          busOut.tag <= qbm_pkg::TAG_WRITE_DATA;
          busOut.id <= {1'b0, priority_level_code};
          busOut.mask <= byteMask_ff[3:0];
          busOut.valid <= 1'b1;
          transmit_word_select_ff <= 1'b1;
          state_ff <= ST_WD2;
        end
        ST_WD2: begin
          busOut.data <= txFile_ff[txPtr];
          busOut.tag <= qbm_pkg::TAG_WRITE_DATA;
          busOut.id <= {1'b0, priority_level_code};
          busOut.mask <= byteMask_ff[7:4];
          busOut.valid <= 1'b1;
          state_ff <= ST_CNF;
        end
        ST_CNF: begin
          transmit_word_select_ff <= 1'b0;
          if (confirmation_in == qbm_pkg::CNF_ERR || confirm_timeout_expired) begin
            state_ff <= ST_IDLE;
          end else if (confirmation_in == qbm_pkg::CNF_ACK) begin
            state_ff <= isRead ? ST_RDWAIT : ST_IDLE;
          end else begin
            state_ff <= ST_ARB;
          end
        end
        ST_RDWAIT: begin
          if (goClear) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timeout counter, started by the command/address tag
  always_ff @(posedge clk) begin
    if (rst) begin
      toCnt_ff <= 32'h0;
      toRun_ff <= 1'b0;
    end else if (goClear || state_ff == ST_IDLE) begin
      toRun_ff <= 1'b0;
      toCnt_ff <= 32'h0;
    end else if (state_ff == ST_CA && !toRun_ff) begin
      toRun_ff <= 1'b1;
      toCnt_ff <= 32'h0;
    end else if (state_ff == ST_CNF && confirmation_in == qbm_pkg::CNF_ACK) begin
      toCnt_ff <= 32'h0;
    end else if (toRun_ff) begin
      toCnt_ff <= toCnt_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error flags: set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_addr_timeout_error_ff <= 1'b0;
      cmd_addr_error_flag_ff <= 1'b0;
      read_data_timeout_ff <= 1'b0;
    end else begin
      if (state_ff == ST_CNF && confirmation_in != qbm_pkg::CNF_ACK
          && confirmation_in != qbm_pkg::CNF_ERR && confirm_timeout_expired) begin
        cmd_addr_timeout_error_ff <= 1'b1;
      end else if (clrErr) begin
        cmd_addr_timeout_error_ff <= 1'b0;
      end
      if (state_ff == ST_CNF && confirmation_in == qbm_pkg::CNF_ERR) begin
        cmd_addr_error_flag_ff <= 1'b1;
      end else if (clrErr) begin
        cmd_addr_error_flag_ff <= 1'b0;
      end
      if (state_ff == ST_RDWAIT && confirm_timeout_expired && !finishOk) begin
        read_data_timeout_ff <= 1'b1;
      end else if (clrErr) begin
        read_data_timeout_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive read data
  always_ff @(posedge clk) begin
    if (rst) begin
      expect_longword_flop_ff <= 1'b0;
      expect_quadword_flop_ff <= 1'b0;
      first_longword_received_ff <= 1'b0;
      rxWord0 <= 32'h0;
      rxWord1 <= 32'h0;
    end else if (state_ff == ST_CNF && confirmation_in == qbm_pkg::CNF_ACK && isRead) begin
      expect_longword_flop_ff <= 1'b1;
      expect_quadword_flop_ff <= 1'b1;
      first_longword_received_ff <= 1'b0;
    end else if (state_ff == ST_RDWAIT && rxGood && receive_file_write_enable) begin
      if (!first_longword_received_ff) begin
        rxWord0 <= busIn.data;
        first_longword_received_ff <= 1'b1;
        expect_longword_flop_ff <= 1'b0;
      end else begin
        rxWord1 <= busIn.data;
        expect_quadword_flop_ff <= 1'b0;
      end
    end else if (abort) begin
      expect_longword_flop_ff <= 1'b0;
      expect_quadword_flop_ff <= 1'b0;
    end
  end

  chk_wd2_mask: assert property (state_ff == ST_WD2
    |=> busOut.mask == $past(byteMask_ff[7:4])) else $error("second mask wrong");
  chk_err_sets: assert property (state_ff == ST_CNF
    && confirmation_in == qbm_pkg::CNF_ERR |=> cmd_addr_error_flag_ff && state_ff == ST_IDLE)
    else $error("error confirm not handled");
  chk_ca_tag: assert property (state_ff == ST_CA
    |=> busOut.tag == qbm_pkg::TAG_CMD_ADDR && busOut.valid) else $error("cmd tag missing");
  chk_ack_done: assert property (finishOk && !activeB_ff
    |=> section_a_done && !goA_ff) else $error("go not cleared on finish");
  chk_arb_hold: assert property (state_ff == ST_ARB && higherPending
    |=> state_ff == ST_ARB && !busOut.valid) else $error("bus taken over higher request");
  chk_rd_expect: assert property (state_ff == ST_CNF && isRead
    && confirmation_in == qbm_pkg::CNF_ACK |=> expect_longword_flop_ff)
    else $error("read not handed over");
endmodule // qbm_engine
`default_nettype wire

// ### sim/qbm_node_model.sv
// Purpose: Behavioural backplane node that confirms attempts and returns read data
// Assumes: Confirmation stands while the last word of an attempt is on the bus
// Notes: Released read lines toggle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module qbm_node_model (
  input wire logic clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic [3:0] level, // Engine priority level
  input wire qbm_pkg::qbm_busword_t busOut, // Words from the engine
  input wire logic [1:0] cnfMode, // Final confirmation code
  input wire logic [3:0] busyN, // Busy answers before the final one
  input wire logic noData, // Withhold read data
  input wire logic [31:0] rdData0, // First read longword
  input wire logic [31:0] rdData1, // Second read longword
  output var logic [1:0] confirmation_in, // Confirmation to engine
  output var qbm_pkg::qbm_rxword_t busIn = '0 // Returned read data
);
  int words;
  int tries;
  int gap;
  logic isRead;
  logic nowRead;
  logic lastWord;
  logic [4:0] ourId;
  assign ourId = {1'b0, level};
  ////////////////////////////////////////////////////////////
  // Answer while the last word of an attempt is still on the bus
  always_comb begin
    nowRead = isRead;
    if (busOut.tag === qbm_pkg::TAG_CMD_ADDR) nowRead = busOut.data[qbm_pkg::CMD_READ_BIT];
    lastWord = busOut.valid === 1'b1 && (nowRead ? busOut.tag === qbm_pkg::TAG_CMD_ADDR
      : (busOut.tag !== qbm_pkg::TAG_CMD_ADDR && words == 1));
    confirmation_in = qbm_pkg::CNF_NONE;
    if (lastWord) confirmation_in = (tries < int'(busyN)) ? qbm_pkg::CNF_BUSY : cnfMode;
  end
  always @(posedge clk) begin
    busIn.valid <= 1'b0;
    busIn.data <= ~busIn.data;
    if (rst) begin
      tries <= 0;
      gap <= 0;
      words <= 0;
      isRead <= 1'b0;
    end else begin
      if (busOut.valid === 1'b1) begin
        if (busOut.tag === qbm_pkg::TAG_CMD_ADDR) begin
          isRead <= nowRead;
          words <= 0;
        end else begin
          words <= words + 1;
        end
      end
      if (lastWord) tries <= (tries < int'(busyN)) ? tries + 1 : 0;
      if (lastWord && nowRead && cnfMode == qbm_pkg::CNF_ACK && !noData) begin
        gap <= 1;
      end else if (gap == 8) begin
        gap <= 0;
      end else if (gap > 0) begin
        gap <= gap + 1;
      end
      // Foreign ID, then bad parity, then the two good longwords
      if (gap == 5) busIn <= '{~rdData0, qbm_pkg::TAG_READ_DATA, ourId ^ 5'h01, 1'b1, 1'b1};
      if (gap == 6) busIn <= '{~rdData1, qbm_pkg::TAG_READ_DATA, ourId, 1'b0, 1'b1};
      if (gap == 7) busIn <= '{rdData0, qbm_pkg::TAG_READ_DATA, ourId, 1'b1, 1'b1};
      if (gap == 8) busIn <= '{rdData1, qbm_pkg::TAG_READ_DATA, ourId, 1'b1, 1'b1};
    end
  end
endmodule // qbm_node_model
`default_nettype wire

// ### sim/tb_qbm_engine.sv
// Purpose: Self-checking bench for the quadword bus master engine
// Assumes: Node model on the far side, timeout shortened to 50 cycles
// Notes: Random data from a fixed seed among handpicked corner cases
`timescale 1ns/10ps
`default_nettype none
module tb_qbm_engine;
  localparam logic [3:0] LVL = 4'h5;
  localparam int TMO = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [15:0] arbIn = 16'h0;
  logic [15:0] arbOut;
  qbm_pkg::qbm_busword_t busOut;
  logic [1:0] cnf;
  qbm_pkg::qbm_rxword_t busIn;
  logic [31:0] rxWord0;
  logic [31:0] rxWord1;
  logic doneA;
  logic doneB;
  logic [1:0] cnfMode = qbm_pkg::CNF_ACK;
  logic [3:0] busyN = 4'h0;
  logic noData = 1'b0;
  logic [31:0] rdData0 = 32'h0;
  logic [31:0] rdData1 = 32'h0;
  int badCount = 0;
  int testsRun = 0;
  int seed = 28;
  int doneCntA = 0;
  int doneCntB = 0;
  int k;
  qbm_pkg::qbm_busword_t seenQ[$];
  logic [31:0] ca, st, q, d0, d1;
  logic [7:0] bm;
  always #20 clk = ~clk;
  qbm_engine #(.TIMEOUT_CYCLES(TMO)) dut_u (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .priority_level_code(LVL), .arbIn(arbIn), .arbOut(arbOut),
    .busOut(busOut), .confirmation_in(cnf), .busIn(busIn), .rxWord0(rxWord0),
    .rxWord1(rxWord1), .section_a_done(doneA), .section_b_done(doneB));
  qbm_node_model node_u (.clk(clk), .rst(rst), .level(LVL), .busOut(busOut), .cnfMode(cnfMode),
    .busyN(busyN), .noData(noData), .rdData0(rdData0), .rdData1(rdData1),
    .confirmation_in(cnf), .busIn(busIn));
  always @(posedge clk) begin
    if (busOut.valid === 1'b1) seenQ.push_back(busOut);
    if (doneA === 1'b1) doneCntA++;
    if (doneB === 1'b1) doneCntB++;
  end
  ////////////////////////////////////////////////////////////
  task automatic final_report;
    if (badCount == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_op(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      badCount++;
      final_report();
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (wr) chk(32'(n >= qbm_pkg::LATCH_HOLD_CYC), 32'h1);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus_op(1'b0, qbm_pkg::OFS_CONTROL, 32'h0);
      n++;
    end while (q[1:0] !== 2'b00 && n < 200);
    if (n >= 200) begin
      badCount++;
      final_report();
    end
    st = q;
  endtask
  task automatic go(input logic [31:0] ctl, input logic [1:0] m, input logic nd);
    seenQ.delete();
    k = doneCntA;
    cnfMode <= m;
    noData <= nd;
    bus_op(1'b1, qbm_pkg::OFS_CONTROL, ctl);
  endtask
  task automatic load_write(input logic [31:0] a, input logic [31:0] w0, input logic [31:0] w1);
    bus_op(1'b1, qbm_pkg::OFS_CMD_ADDR, a);
    bus_op(1'b1, qbm_pkg::OFS_TX_FILE, w0);
    bus_op(1'b1, qbm_pkg::OFS_TX_FILE, w1);
  endtask
  task automatic chk_write(input int i, input logic [31:0] a, input logic [31:0] w0,
                           input logic [31:0] w1, input logic [7:0] m);
    chk(seenQ[i].data, a);
    chk(32'({seenQ[i].tag, seenQ[i].id}), 32'({qbm_pkg::TAG_CMD_ADDR, 1'b0, LVL}));
    chk(seenQ[i+1].data, w0);
    chk(seenQ[i+2].data, w1);
    chk(32'({seenQ[i+1].tag, seenQ[i+1].mask, seenQ[i+2].tag, seenQ[i+2].mask}),
        32'({qbm_pkg::TAG_WRITE_DATA, m[3:0], qbm_pkg::TAG_WRITE_DATA, m[7:4]}));
  endtask
  function automatic logic [31:0] next_ca(input logic [31:0] a);
    next_ca = a;
    next_ca[8:1] = a[8:1] + 8'h01;
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      ca = {4'h2, 28'($random(seed))};
      d0 = $random(seed);
      d1 = $random(seed);
      bm = 8'($random(seed));
      if (i == 0) arbIn <= 16'h0004;
      load_write(ca, d0, d1);
      bus_op(1'b1, qbm_pkg::OFS_BYTE_MASK, {24'h0, bm});
      go(32'h1, qbm_pkg::CNF_ACK, 1'b0);
      if (i == 0) begin
        bus_op(1'b0, qbm_pkg::OFS_CONTROL, 32'h0);
        chk(32'({q[2], q[0]}), 32'h3);
        repeat (20) @(posedge clk);
        chk(32'(seenQ.size()), 32'h0);
        chk(32'(arbOut), 32'h20);
      end
      arbIn <= 16'($random(seed)) & 16'hFFC0;
      wait_idle();
      chk(32'(seenQ.size()), 32'h3);
      chk_write(0, ca, d0, d1, bm);
      chk(32'(doneCntA), 32'(i + 1));
    end
    // Section B, no reload, default mask, two busy answers
    d0 = $random(seed);
    d1 = $random(seed);
    bus_op(1'b1, qbm_pkg::OFS_TX_FILE, d0);
    bus_op(1'b1, qbm_pkg::OFS_TX_FILE, d1);
    busyN <= 4'h2;
    go(32'h2, qbm_pkg::CNF_ACK, 1'b0);
    wait_idle();
    busyN <= 4'h0;
    chk(32'(seenQ.size()), 32'h9);
    chk(seenQ[0].data, next_ca(ca));
    chk_write(6, next_ca(ca), d0, d1, qbm_pkg::MASK_RESET);
    chk(32'(doneCntB), 32'h1);
    ca = {4'h2, 28'($random(seed))};
    load_write(ca, d1, d0);
    go(32'h1, qbm_pkg::CNF_ERR, 1'b0);
    wait_idle();
    chk(32'(seenQ.size()), 32'h3);
    chk(32'(st[5]), 32'h1);
    bus_op(1'b1, qbm_pkg::OFS_CONTROL, 32'h4);
    go(32'h1, qbm_pkg::CNF_NONE, 1'b0);
    wait_idle();
    chk(32'(st[5:4]), 32'h1);
    chk(32'(seenQ.size() >= 6 && seenQ.size() <= 3 * (TMO / 4 + 2)), 32'h1);
    bus_op(1'b1, qbm_pkg::OFS_CONTROL, 32'h4);
    ca = {4'h3, 28'($random(seed))};
    rdData0 <= $random(seed);
    rdData1 <= $random(seed);
    bus_op(1'b1, qbm_pkg::OFS_CMD_ADDR, ca);
    go(32'h1, qbm_pkg::CNF_ACK, 1'b0);
    wait_idle();
    chk(32'(seenQ.size()), 32'h1);
    chk(rxWord0, rdData0);
    chk(rxWord1, rdData1);
    chk(32'(doneCntA), 32'(k + 1));
    bus_op(1'b0, qbm_pkg::OFS_TX_FILE, 32'h0);
    chk(q, rdData0);
    go(32'h1, qbm_pkg::CNF_ACK, 1'b1);
    wait_idle();
    chk(32'(st[6]), 32'h1);
    final_report();
  end
endmodule // tb_qbm_engine
`default_nettype wire
